//--- system_manager_access_port_consts.vh
`ifndef SYSTEM_MANAGER_ACCESS_PORT_CONSTS_VH
`define SYSTEM_MANAGER_ACCESS_PORT_CONSTS_VH
// register byte offsets
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL     8'h00
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT     8'h04
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR      8'h08
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR     8'h0c
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN      8'h10
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA     8'h14
`define SYSTEM_MANAGER_ACCESS_PORT_OFS_REV      8'h28
// control bits
`define SYSTEM_MANAGER_ACCESS_PORT_CB_EN        0
`define SYSTEM_MANAGER_ACCESS_PORT_CB_DIS       1
`define SYSTEM_MANAGER_ACCESS_PORT_CB_CRC       2
`define SYSTEM_MANAGER_ACCESS_PORT_CB_UPR       3
`define SYSTEM_MANAGER_ACCESS_PORT_CB_CE        4
// status bits
`define SYSTEM_MANAGER_ACCESS_PORT_SB_DONE      0
`define SYSTEM_MANAGER_ACCESS_PORT_SB_HCR       1
`define SYSTEM_MANAGER_ACCESS_PORT_SB_BUS_ERROR_FLAG      2
`define SYSTEM_MANAGER_ACCESS_PORT_SB_FAIL      3
`define SYSTEM_MANAGER_ACCESS_PORT_SB_LCK       4
`define SYSTEM_MANAGER_ACCESS_PORT_SB_EN        8
`define SYSTEM_MANAGER_ACCESS_PORT_SB_PROTECTED_FLAG      9
`define SYSTEM_MANAGER_ACCESS_PORT_SB_DBG       10
`define SYSTEM_MANAGER_ACCESS_PORT_SB_STLO      24
`define SYSTEM_MANAGER_ACCESS_PORT_SB_STHI      26
// operation state codes
`define SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE      3'h0
`define SYSTEM_MANAGER_ACCESS_PORT_ST_CE        3'h1
`define SYSTEM_MANAGER_ACCESS_PORT_ST_CRC       3'h2
`define SYSTEM_MANAGER_ACCESS_PORT_ST_UPR       3'h3
// crc polynomial, reflected form
`define SYSTEM_MANAGER_ACCESS_PORT_CRC_POLY     32'hedb88320
// defaults
`define SYSTEM_MANAGER_ACCESS_PORT_ZERO32       32'h00000000
`define SYSTEM_MANAGER_ACCESS_PORT_WORD_MASK    32'hfffffffc
`define SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP    32'h00000004
`define SYSTEM_MANAGER_ACCESS_PORT_REV_VALUE    32'h00000100
`define SYSTEM_MANAGER_ACCESS_PORT_FLASH_BASE   32'h00000000
`define SYSTEM_MANAGER_ACCESS_PORT_FLASH_LEN    32'h00080000
`define SYSTEM_MANAGER_ACCESS_PORT_CRC_SEED     32'hffffffff
`define SYSTEM_MANAGER_ACCESS_PORT_PAGE_MASK    32'h000001fc
`endif

//--- system_manager_access_port_sync.v
`timescale 1ns/1ns
// three stage synchroniser; change accepted when stages two and three agree
module system_manager_access_port_sync (
  input  wire clock,
  input  wire sys_rst,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // s1 only feeds s2
  always @(posedge clock) begin
    if (sys_rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      dout   <= 1'b1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule

//--- system_manager_access_port_crc32.v
`timescale 1ns/1ns
`include "system_manager_access_port_consts.vh"
// one 32-bit word folded into a reflected crc32, lsb first
module system_manager_access_port_crc32 (
  input  wire [31:0] crc_in,
  input  wire [31:0] word,
  output reg  [31:0] crc_out
);
  integer i;
  reg [31:0] c;

  // combinational fold, 32 bit steps in one cycle
  always @* begin
    c = crc_in ^ word;
    for (i = 0; i < 32; i = i + 1) begin
      if (c[0])
        c = (c >> 1) ^ `SYSTEM_MANAGER_ACCESS_PORT_CRC_POLY;
      else
        c = c >> 1;
    end
    crc_out = c;
  end
endmodule

//--- system_manager_access_port_access_port.v
`timescale 1ns/1ns
`include "system_manager_access_port_consts.vh"
module system_manager_access_port_access_port (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  input  wire        test_clk,
  input  wire        protected_flag_in,
  input  wire        hold_req,
  output wire        hold_core_reset,
  output wire        erase_req,
  input  wire        erase_done,
  input  wire        erase_fail,
  output wire        mem_req,
  output wire [31:0] mem_addr,
  output wire        mem_upage,
  input  wire        mem_ack,
  input  wire        mem_err,
  input  wire [31:0] mem_rdata
);

  // operation state and its next value; codes match the status field
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  // enable and the status flag bits, one register per flag
  reg         en_reg;
  reg         protected_flag_reg;
  reg         dbg_reg;
  reg         lck_reg;
  reg         fail_reg;
  reg         bus_error_flag_reg;
  reg         hcr_reg;
  reg         done_reg;
  // user visible address, length and data registers
  reg  [31:0] addr_reg;
  reg  [31:0] len_reg;
  reg  [31:0] data_reg;
  // edge detector history and strap capture marker
  reg         tck_prev_reg;
  reg         protected_flag_seen_reg;
  // internal nets: synced pin, crc result and decoded strobes
  wire        tck_s;
  wire [31:0] crc_new;
  wire        wr_ok;
  wire        busy;
  wire        hide_ad;
  wire        w_ctrl;
  wire        w_clr;
  wire        go_ce;
  wire        go_crc;
  wire        go_upr;
  wire        dis;
  wire [31:0] st_word;

  // the test clock pin is asynchronous to clock; it only ever feeds
  // the debugger flag, so three stages of latency cost nothing, and
  // the agree rule keeps a single metastable sample from counting
  system_manager_access_port_sync u_tck (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (test_clk),
    .dout    (tck_s)
  );


  // crc fold works on the word the memory returns this cycle; the
  // whole 32 bit step is combinational, which trades a long path for
  // one word per acknowledge and no extra counter
  system_manager_access_port_crc32 u_crc (
    .crc_in  (data_reg),
    .word    (mem_rdata),
    .crc_out (crc_new)
  );


  // decoded register strobes; writes ignored while disabled
  // the control register is decoded without the enable so that the
  // enable bit itself can be written; every trigger still needs it.
  // triggers are only taken while idle: a running operation cannot be
  // interrupted except by the disable bit, which wins over all else.
  // when several triggers are written at once the priority is
  // erase, then crc, then user page read
  assign busy    = (state_reg != `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE);
  assign wr_ok   = reg_wr & en_reg;
  assign w_ctrl  = reg_wr & (reg_addr == `SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL);
  assign w_clr   = wr_ok & (reg_addr == `SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR);
  assign dis     = w_ctrl & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_DIS];
  assign go_ce   = w_ctrl & en_reg & ~busy & ~dis & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_CE];
  assign go_crc  = w_ctrl & en_reg & ~busy & ~dis & ~reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_CE]
                   & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_CRC];
  assign go_upr  = w_ctrl & en_reg & ~busy & ~dis & ~reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_CE]
                   & ~reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_CRC] & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_UPR];
  assign hide_ad = protected_flag_reg & busy;


  // memory side requests follow the operation state
  // requests are decoded straight from the state register, so they
  // fall in the cycle after the acknowledge without any extra flop;
  // the user page offset is limited to one page, higher bits dropped
  assign erase_req       = (state_reg == `SYSTEM_MANAGER_ACCESS_PORT_ST_CE);
  assign mem_req         = (state_reg == `SYSTEM_MANAGER_ACCESS_PORT_ST_CRC) |
                           (state_reg == `SYSTEM_MANAGER_ACCESS_PORT_ST_UPR);
  assign mem_upage       = (state_reg == `SYSTEM_MANAGER_ACCESS_PORT_ST_UPR);
  assign mem_addr        = mem_upage ? (addr_reg & `SYSTEM_MANAGER_ACCESS_PORT_PAGE_MASK)
                                     : addr_reg;
  assign hold_core_reset = hcr_reg;


  // next operation state
  // erase waits for the engine, a page read for one word, and a crc
  // for its last word or the first bus error; a bus error aborts the
  // crc so a bad range cannot keep the port busy for ever
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE: begin
        if (go_ce)
          state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_CE;
        else if (go_crc)
          state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_CRC;
        else if (go_upr)
          state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_UPR;
      end
      `SYSTEM_MANAGER_ACCESS_PORT_ST_CE: begin
        if (erase_done)
          state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
      end
      `SYSTEM_MANAGER_ACCESS_PORT_ST_CRC: begin
        if (mem_ack & (mem_err | (len_reg <= `SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP)))
          state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
      end
      `SYSTEM_MANAGER_ACCESS_PORT_ST_UPR: begin
        if (mem_ack)
          state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
      end
      default: state_next = `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
    endcase
  end


  // main sequential process; disable acts like reset except protection, debug and hold
  // protection and the debugger flag survive a disable on purpose:
  // otherwise a disable would be a way out of the protected state.
  // the hold request is a level from the reset sequencer and keeps the
  // core held whatever the register side does.
  // within one cycle a hardware set always wins over a software clear,
  // so an event that lands with the clear write is never lost
  always @(posedge clock) begin
    if (sys_rst) begin
      state_reg     <= `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
      en_reg        <= 1'b0;
      protected_flag_reg      <= 1'b0;
      protected_flag_seen_reg <= 1'b0;
      dbg_reg       <= 1'b0;
      lck_reg       <= 1'b0;
      fail_reg      <= 1'b0;
      bus_error_flag_reg      <= 1'b0;
      hcr_reg       <= 1'b0;
      done_reg      <= 1'b0;
      addr_reg      <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
      len_reg       <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
      data_reg      <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
      tck_prev_reg  <= 1'b1;
    end else begin
      tck_prev_reg <= tck_s;
      // protection strap caught once after reset release
      if (!protected_flag_seen_reg) begin
        protected_flag_seen_reg <= 1'b1;
        protected_flag_reg      <= protected_flag_in;
      end
      if (tck_prev_reg & ~tck_s)
        dbg_reg <= 1'b1;
      if (dis) begin
        state_reg <= `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
        en_reg    <= 1'b0;
        lck_reg   <= 1'b0;
        fail_reg  <= 1'b0;
        bus_error_flag_reg  <= 1'b0;
        done_reg  <= 1'b0;
        addr_reg  <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
        len_reg   <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
        data_reg  <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
        if (hold_req)
          hcr_reg <= 1'b1;
      end else begin
        state_reg <= state_next;
        if (w_ctrl & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_CB_EN])
          en_reg <= 1'b1;
        if (w_clr & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_SB_DONE])
          done_reg <= 1'b0;
        if (w_clr & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_SB_BUS_ERROR_FLAG])
          bus_error_flag_reg <= 1'b0;
        if (w_clr & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_SB_FAIL])
          fail_reg <= 1'b0;
        if (w_clr & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_SB_LCK])
          lck_reg <= 1'b0;
        if (w_clr & reg_wdata[`SYSTEM_MANAGER_ACCESS_PORT_SB_HCR] & ~protected_flag_reg)
          hcr_reg <= 1'b0;
        if (hold_req)
          hcr_reg <= 1'b1;
        // register writes; protected busy and length blocked
        if (wr_ok & ~busy & ~hide_ad & (reg_addr == `SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR))
          addr_reg <= reg_wdata & `SYSTEM_MANAGER_ACCESS_PORT_WORD_MASK;
        if (wr_ok & ~busy & ~protected_flag_reg & (reg_addr == `SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN))
          len_reg <= reg_wdata & `SYSTEM_MANAGER_ACCESS_PORT_WORD_MASK;
        if (wr_ok & ~busy & ~hide_ad & (reg_addr == `SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA))
          data_reg <= reg_wdata;
        if (go_crc & protected_flag_reg) begin
          addr_reg <= `SYSTEM_MANAGER_ACCESS_PORT_FLASH_BASE;
          len_reg  <= `SYSTEM_MANAGER_ACCESS_PORT_FLASH_LEN;
          data_reg <= `SYSTEM_MANAGER_ACCESS_PORT_CRC_SEED;
          lck_reg  <= 1'b1;
        end
        // zero length crc ends at once
        if (go_crc & ~protected_flag_reg & (len_reg == `SYSTEM_MANAGER_ACCESS_PORT_ZERO32))
          state_reg <= `SYSTEM_MANAGER_ACCESS_PORT_ST_IDLE;
        if (go_crc & ~protected_flag_reg & (len_reg == `SYSTEM_MANAGER_ACCESS_PORT_ZERO32))
          done_reg <= 1'b1;
        case (state_reg)
          `SYSTEM_MANAGER_ACCESS_PORT_ST_CE: begin
            if (erase_done) begin
              done_reg <= 1'b1;
              if (erase_fail)
                fail_reg <= 1'b1;
              else
                protected_flag_reg <= 1'b0;
            end
          end
          `SYSTEM_MANAGER_ACCESS_PORT_ST_CRC: begin
            // the fetch address and remaining length move together, so
            // after the run they point just past the area that was read;
            // on a bus error both stay at the failing word
            if (mem_ack) begin
              if (mem_err) begin
                bus_error_flag_reg <= 1'b1;
                done_reg <= 1'b1;
              end else begin
                data_reg <= crc_new;
                addr_reg <= addr_reg + `SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP;
                len_reg  <= (len_reg <= `SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP) ? `SYSTEM_MANAGER_ACCESS_PORT_ZERO32
                            : len_reg - `SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP;
                if (len_reg <= `SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP)
                  done_reg <= 1'b1;
              end
            end
          end
          `SYSTEM_MANAGER_ACCESS_PORT_ST_UPR: begin
            if (mem_ack) begin
              done_reg <= 1'b1;
              if (mem_err)
                bus_error_flag_reg <= 1'b1;
              else
                data_reg <= mem_rdata;
              addr_reg <= addr_reg + `SYSTEM_MANAGER_ACCESS_PORT_WORD_STEP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end


  // status word assembly; reserved bits read zero
  // the state field is the live state register, so a poll shows the
  // operation running until the cycle in which done is set
  assign st_word = {5'h00, state_reg, 13'h0000, dbg_reg, protected_flag_reg, en_reg,
                    3'h0, lck_reg, fail_reg, bus_error_flag_reg, hcr_reg, done_reg};


  // read data register; write-only and unmapped read zero
  // read data stand for one cycle only and are zero otherwise, so a
  // late sample on the debug side sees zero rather than old data;
  // while disabled every read returns zero
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
    end else if (reg_rd & en_reg) begin
      case (reg_addr)
        `SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT: reg_rdata <= st_word;
        `SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR: reg_rdata <= hide_ad ? `SYSTEM_MANAGER_ACCESS_PORT_ZERO32 : addr_reg;
        `SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN:  reg_rdata <= protected_flag_reg ? `SYSTEM_MANAGER_ACCESS_PORT_ZERO32 : len_reg;
        `SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA: reg_rdata <= hide_ad ? `SYSTEM_MANAGER_ACCESS_PORT_ZERO32 : data_reg;
        `SYSTEM_MANAGER_ACCESS_PORT_OFS_REV:  reg_rdata <= `SYSTEM_MANAGER_ACCESS_PORT_REV_VALUE;
        default:        reg_rdata <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
      endcase
    end else begin
      reg_rdata <= `SYSTEM_MANAGER_ACCESS_PORT_ZERO32;
    end
  end
endmodule

//--- system_manager_access_port_access_port_sva.sv
`timescale 1ns/1ns
module system_manager_access_port_access_port_sva (
  input wire        clock,
  input wire        sys_rst,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire [31:0] reg_wdata,
  input wire        hold_req,
  input wire        hold_core_reset,
  input wire        erase_req,
  input wire        erase_done,
  input wire        mem_req,
  input wire [31:0] mem_addr,
  input wire        mem_upage,
  input wire        mem_ack
);
  wire wr_ctl = reg_wr && reg_addr == 8'h00;
  wire dis = wr_ctl && reg_wdata[1];
  wire idle = !erase_req && !mem_req;
  reg  en_reg;
  // enable is not at the ports, so keep a shadow; disable wins
  always @(posedge clock)
    if (sys_rst || dis) en_reg <= 1'b0;
    else if (wr_ctl && reg_wdata[0]) en_reg <= 1'b1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_erase_starts: assert property (
    wr_ctl && reg_wdata == 32'h10 && en_reg && idle |=> erase_req)
    else $error("erase not started");
  a_upr_starts: assert property (
    wr_ctl && reg_wdata == 32'h8 && en_reg && idle |=> mem_req && mem_upage)
    else $error("page read not started");
  a_dis_aborts: assert property (dis |=> idle)
    else $error("operation survived disable");
  a_erase_holds: assert property (
    erase_req && !erase_done && !dis |=> erase_req)
    else $error("erase dropped early");
  a_mem_stable: assert property (
    mem_req && !mem_ack && !dis |=> mem_req && $stable(mem_addr))
    else $error("fetch changed before ack");
  a_word_fetch: assert property (
    mem_req |-> mem_addr[1:0] == 2'b00) else $error("unaligned fetch");
  a_single_op: assert property (!(erase_req && mem_req))
    else $error("two operations at once");
  a_hold_sets: assert property (
    hold_req |-> ##[1:2] hold_core_reset) else $error("core not held");
endmodule
bind system_manager_access_port_access_port system_manager_access_port_access_port_sva chk_u (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .hold_req(hold_req),
  .hold_core_reset(hold_core_reset), .erase_req(erase_req),
  .erase_done(erase_done), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_upage(mem_upage), .mem_ack(mem_ack));

//--- system_manager_access_port_mem_model.sv
`timescale 1ns/1ns
// memory and erase engine behind the port; answers lat cycles late
module system_manager_access_port_mem_model (
  input  wire        clock,
  input  wire [3:0]  lat,
  input  wire        erase_bad,
  input  wire        erase_req,
  output reg         erase_done,
  output reg         erase_fail,
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  input  wire        mem_upage,
  output reg         mem_ack,
  output reg         mem_err,
  output reg  [31:0] mem_rdata
);
  reg [3:0] wait_reg;
  wire busy = (mem_req && !mem_ack) || (erase_req && !erase_done);
  wire fire = busy && wait_reg == lat;
  // quiet start
  initial begin
    wait_reg = 4'h0;
    {erase_done, erase_fail, mem_ack, mem_err} = 4'h0;
    mem_rdata = 32'h0;
  end
  // words from 1 MiB up answer with a bus error
  always @(posedge clock) begin
    wait_reg <= (fire || !busy) ? 4'h0 : wait_reg + 4'h1;
    mem_ack <= fire && mem_req;
    erase_done <= fire && erase_req;
    erase_fail <= fire && erase_req && erase_bad;
    mem_err <= fire && mem_req && mem_addr >= 32'h00100000;
    // an idle data bus toggles so a stale word can never pass
    mem_rdata <= (fire && mem_req) ?
      {mem_upage ? 8'h5e : 8'hc0, 15'h0, mem_addr[8:0]} : ~mem_rdata;
  end
endmodule

//--- system_manager_access_port_access_port_tb.sv
`timescale 1ns/1ns
`include "system_manager_access_port_consts.vh"
module system_manager_access_port_access_port_tb;
  reg         clock, sys_rst, reg_wr, reg_rd, test_clk, protected_flag_in, hold_req;
  reg         erase_bad;
  reg  [3:0]  lat;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata, v;
  wire [31:0] reg_rdata, mem_addr, mem_rdata;
  wire        hold_core_reset, erase_req, erase_done, erase_fail;
  wire        mem_req, mem_upage, mem_ack, mem_err;
  integer     err_total, total_checks, i;
  system_manager_access_port_access_port dut_u (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .test_clk(test_clk), .protected_flag_in(protected_flag_in),
    .hold_req(hold_req), .hold_core_reset(hold_core_reset),
    .erase_req(erase_req), .erase_done(erase_done),
    .erase_fail(erase_fail), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_upage(mem_upage), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata));
  system_manager_access_port_mem_model mem_u (
    .clock(clock), .lat(lat), .erase_bad(erase_bad),
    .erase_req(erase_req), .erase_done(erase_done),
    .erase_fail(erase_fail), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_upage(mem_upage), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata));
  // 50 ns clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  // one-cycle strobes, launched at the falling edge
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      v = reg_rdata;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(v, e);
    end
  endtask
  task wait_done;
    begin
      v = 32'h0;
      for (i = 0; i < 60 && v[0] !== 1'b1; i = i + 1)
        rd(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT);
      chk({31'h0, v[0]}, 32'h1);
    end
  endtask
  function [31:0] crc_w(input [31:0] c, input [31:0] w);
    integer k;
    begin
      c = c ^ w;
      for (k = 0; k < 32; k = k + 1)
        c = c[0] ? (c >> 1) ^ `SYSTEM_MANAGER_ACCESS_PORT_CRC_POLY : c >> 1;
      crc_w = c;
    end
  endfunction
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // a hang is cut after about 5000 cycles
  initial begin
    #250000;
    err_total = err_total + 1;
    finish_test;
  end
  // main sequence; the strap starts the part protected
  initial begin
    {sys_rst, protected_flag_in, test_clk} = 3'h7;
    {reg_wr, reg_rd, hold_req, erase_bad} = 4'h0;
    {reg_addr, reg_wdata, lat} = 44'h0;
    err_total = 0;
    total_checks = 0;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h0);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h10);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h1);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h0);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_REV, `SYSTEM_MANAGER_ACCESS_PORT_REV_VALUE);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h0);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN, 32'h40);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN, 32'h0);
    hold_req = 1'b1;
    @(negedge clock);
    hold_req = 1'b0;
    test_clk = 1'b0;
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h2);
    repeat (4) @(negedge clock);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h702);
    lat = 4'hf;
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h8);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h8);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h0);
    rd(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT);
    chk({29'h0, v[26:24]}, 32'h3);
    wait_done;
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA, {8'h5e, 15'h0, 9'h8});
    lat = 4'h0;
    // stale done would let the poll pass before the new read lands
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h1);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h8);
    wait_done;
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA, {8'h5e, 15'h0, 9'hc});
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h10);
    lat = 4'h8;
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h1);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h10);
    rd(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT);
    chk({29'h0, v[26:24]}, 32'h1);
    wait_done;
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h503);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h3);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h500);
    chk({31'h0, hold_core_reset}, 32'h0);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN, 32'h13);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN, 32'h10);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h103);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h100);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN, 32'h8);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA, 32'hffffffff);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h4);
    wait_done;
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_DATA, crc_w(crc_w(32'hffffffff, 32'hc0000100),
      32'hc0000104));
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h108);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h1f);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_ADDR, 32'h00100000);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_LEN, 32'h4);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h4);
    wait_done;
    chk({31'h0, v[2]}, 32'h1);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h1f);
    erase_bad = 1'b1;
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h10);
    wait_done;
    chk({31'h0, v[3]}, 32'h1);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CLR, 32'h1f);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h500);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h8);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h2);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h0);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h1);
    wr(`SYSTEM_MANAGER_ACCESS_PORT_OFS_CTRL, 32'h0);
    rdc(`SYSTEM_MANAGER_ACCESS_PORT_OFS_STAT, 32'h500);
    finish_test;
  end
endmodule
